// ==== hdl/bac_pkg.sv ====
// Purpose: shared constants, settings map and carriers for the battery alarm/calibration block
// Assumes: settings bytes are delivered by the SMBus slave front end as index/data strobes
// Notes:   16-bit settings occupy two indices, low byte first
//
// Functional notes
// - bus settings byte decodes arbitration, CRC, PEC, baud.
// - overheat threshold coded as Celsius*10 plus 200.
// - overheat flag above threshold; stop-charging when charging.
// - low capacity sets status flag, optional broadcast.
// - low runtime sets status flag; default 10 minutes.
// - answer at configurable slave address, typically 0x16.
// - calibration flags: bits 7..4 per quantity, 3..0 unused.
// - current = (raw - offset - deviation)*gain/16384.
// - current offset is signed 8-bit, -128..127.
// - current scaled by 16-bit gain up to 65535.
// - thermistor temperature uses its own separate gain.
// - internal temperature sensor uses zero offset.
// - pack voltage uses 16-bit gain, signed 8-bit offset.
package bac_pkg;

	localparam int unsigned NUM_SET = 23;
	localparam int unsigned IDX_W   = 5;

	localparam logic [IDX_W-1:0] IDX_BUS_SETTINGS   = 5'h00;
	localparam logic [IDX_W-1:0] IDX_OVER_TEMP      = 5'h01;
	localparam logic [IDX_W-1:0] IDX_LOW_CAP        = 5'h03;
	localparam logic [IDX_W-1:0] IDX_LOW_RUNTIME    = 5'h05;
	localparam logic [IDX_W-1:0] IDX_SLAVE_ADDR     = 5'h07;
	localparam logic [IDX_W-1:0] IDX_CAL_FLAGS      = 5'h08;
	localparam logic [IDX_W-1:0] IDX_CUR_GAIN       = 5'h09;
	localparam logic [IDX_W-1:0] IDX_THERM_GAIN     = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_INT_TEMP_GAIN  = 5'h0D;
	localparam logic [IDX_W-1:0] IDX_VPACK_GAIN     = 5'h0F;
	localparam logic [IDX_W-1:0] IDX_CUR_OFFSET     = 5'h11;
	localparam logic [IDX_W-1:0] IDX_CUR_AZ_DEV     = 5'h12;
	localparam logic [IDX_W-1:0] IDX_THERM_OFFSET   = 5'h13;
	localparam logic [IDX_W-1:0] IDX_INT_TEMP_OFF   = 5'h14;
	localparam logic [IDX_W-1:0] IDX_VPACK_OFFSET   = 5'h16;

	// typical values loaded at reset
	localparam logic [7:0]  RST_BUS_SETTINGS  = 8'h21;
	localparam logic [15:0] RST_OVER_TEMP     = 16'h02EE;
	localparam logic [15:0] RST_LOW_CAP       = 16'h01B8;
	localparam logic [15:0] RST_LOW_RUNTIME   = 16'h000A;
	localparam logic [7:0]  RST_SLAVE_ADDR    = 8'h16;
	localparam logic [7:0]  RST_CAL_FLAGS     = 8'hF0;
	localparam logic [15:0] RST_CUR_GAIN      = 16'h1ABC;
	localparam logic [15:0] RST_THERM_GAIN    = 16'h0514;
	localparam logic [15:0] RST_INT_TEMP_GAIN = 16'h5CF8;
	localparam logic [15:0] RST_VPACK_GAIN    = 16'h4E4D;
	localparam logic [7:0]  RST_CUR_OFFSET    = 8'hF4;
	localparam logic [7:0]  RST_CUR_AZ_DEV    = 8'hF4;
	localparam logic [7:0]  RST_THERM_OFFSET  = 8'hFE;
	localparam logic [15:0] RST_INT_TEMP_OFF  = 16'hD391;
	localparam logic [7:0]  RST_VPACK_OFFSET  = 8'h00;

	// bus settings fields
	localparam int unsigned BUS_ARB_V2_BIT    = 7;
	localparam int unsigned BUS_MWR_CRC_BIT   = 6;
	localparam int unsigned BUS_PEC_BIT       = 5;
	localparam int unsigned BUS_BAUD_CTRL_BIT = 4;
	localparam int unsigned BUS_BAUD_MSB      = 2;

	// calibration flags fields
	localparam int unsigned CAL_RC_OSCILLATOR_CALIBRATED_BIT     = 7;
	localparam int unsigned CAL_TEMP_BIT      = 6;
	localparam int unsigned CAL_CURRENT_BIT   = 5;
	localparam int unsigned CAL_VPACK_BIT     = 4;
	localparam logic [7:0]  CAL_USED_MASK     = 8'hF0;

	localparam int unsigned GAIN_SHIFT        = 14;
	localparam logic signed [17:0] TEMP_CODE_OFFSET = 18'sh00C8;

	localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

	typedef struct packed {
		logic signed [15:0] current;
		logic signed [15:0] pack_voltage;
		logic signed [15:0] temperature;
		logic               temp_external;
	} bac_raw_t;

	typedef struct packed {
		logic signed [15:0] current_ma;
		logic signed [15:0] pack_voltage;
		logic signed [15:0] temperature;
	} bac_cal_t;

	typedef struct packed {
		logic       arb_v2;
		logic       master_wr_crc;
		logic       pec_enable;
		logic       baud_ctrl;
		logic [2:0] baud_sel;
	} bac_bus_cfg_t;

	function automatic logic [7:0] bac_reset_byte(input logic [IDX_W-1:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			5'h00: v = RST_BUS_SETTINGS;
			5'h01: v = RST_OVER_TEMP[7:0];
			5'h02: v = RST_OVER_TEMP[15:8];
			5'h03: v = RST_LOW_CAP[7:0];
			5'h04: v = RST_LOW_CAP[15:8];
			5'h05: v = RST_LOW_RUNTIME[7:0];
			5'h06: v = RST_LOW_RUNTIME[15:8];
			5'h07: v = RST_SLAVE_ADDR;
			5'h08: v = RST_CAL_FLAGS;
			5'h09: v = RST_CUR_GAIN[7:0];
			5'h0A: v = RST_CUR_GAIN[15:8];
			5'h0B: v = RST_THERM_GAIN[7:0];
			5'h0C: v = RST_THERM_GAIN[15:8];
			5'h0D: v = RST_INT_TEMP_GAIN[7:0];
			5'h0E: v = RST_INT_TEMP_GAIN[15:8];
			5'h0F: v = RST_VPACK_GAIN[7:0];
			5'h10: v = RST_VPACK_GAIN[15:8];
			5'h11: v = RST_CUR_OFFSET;
			5'h12: v = RST_CUR_AZ_DEV;
			5'h13: v = RST_THERM_OFFSET;
			5'h14: v = RST_INT_TEMP_OFF[7:0];
			5'h15: v = RST_INT_TEMP_OFF[15:8];
			5'h16: v = RST_VPACK_OFFSET;
			default: v = 8'h00;
		endcase
		return v;
	endfunction : bac_reset_byte

	// (raw - off_a - off_b) * gain / 16384, truncated toward minus infinity
	function automatic logic signed [15:0] bac_scale_fn(
		input logic signed [15:0] raw,
		input logic signed [15:0] off_a,
		input logic signed [7:0]  off_b,
		input logic        [15:0] gain);
		logic signed [17:0] diff;
		logic signed [35:0] prod;
		diff = 18'(raw) - 18'(off_a) - 18'(off_b);
		prod = 36'(diff) * 36'($signed({1'b0, gain}));
		return prod[GAIN_SHIFT+15:GAIN_SHIFT];
	endfunction : bac_scale_fn

endpackage : bac_pkg

// ==== hdl/bac_scale.sv ====
// Purpose: applies stored gains and offsets to one set of raw readings
// Assumes: raw_valid is a one-cycle pulse per conversion set
// Notes:   result registered one cycle after raw_valid
`timescale 1ns/100ps
`default_nettype none
module bac_scale
	import bac_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               raw_valid,
	input  wire bac_raw_t           raw,
	input  wire logic        [15:0] cur_gain,
	input  wire logic signed [7:0]  cur_offset,
	input  wire logic signed [7:0]  cur_az_dev,
	input  wire logic        [15:0] therm_gain,
	input  wire logic signed [7:0]  therm_offset,
	input  wire logic        [15:0] int_temp_gain,
	input  wire logic        [15:0] vpack_gain,
	input  wire logic signed [7:0]  vpack_offset,
	output bac_cal_t                cal,
	output logic                    cal_valid
);
	logic signed [15:0] next_temp;

	always_comb begin
		if (raw.temp_external) begin
			next_temp = bac_scale_fn(raw.temperature, 16'(therm_offset), 8'sh00, therm_gain);
		end else begin
			next_temp = bac_scale_fn(raw.temperature, 16'sh0000, 8'sh00, int_temp_gain);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cal <= '0;
		end else if (raw_valid) begin
			cal.current_ma   <= bac_scale_fn(raw.current, 16'(cur_offset), cur_az_dev,
				cur_gain);
			cal.pack_voltage <= bac_scale_fn(raw.pack_voltage, 16'(vpack_offset), 8'sh00,
				vpack_gain);
			cal.temperature  <= next_temp;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cal_valid <= 1'b0;
		end else begin
			cal_valid <= raw_valid;
		end
	end
endmodule : bac_scale
`default_nettype wire

// ==== hdl/bac_alarm.sv ====
// Purpose: threshold comparisons for the alarm and pack status flags
// Assumes: temperature is in 0.1 C steps; capacity and runtime from the gauge
// Notes:   flags are levels re-evaluated on every new measurement
`timescale 1ns/100ps
`default_nettype none
module bac_alarm
	import bac_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               cal_valid,
	input  wire logic signed [15:0] temperature,
	input  wire logic               charging,
	input  wire logic               gauge_valid,
	input  wire logic        [15:0] remaining_capacity,
	input  wire logic        [15:0] runtime_estimate,
	input  wire logic        [15:0] over_temp_threshold,
	input  wire logic        [15:0] low_cap_threshold,
	input  wire logic        [15:0] low_runtime_threshold,
	input  wire logic               broadcast_enable,
	output logic                    overheat_flag,
	output logic                    stop_charging_flag,
	output logic                    low_capacity_flag,
	output logic                    low_runtime_flag,
	output logic                    alarm_broadcast
);
	logic signed [17:0] temp_code;
	logic               next_low_cap;

	assign temp_code    = 18'(temperature) + TEMP_CODE_OFFSET;
	assign next_low_cap = remaining_capacity <= low_cap_threshold;

	always_ff @(posedge clk) begin
		if (rst) begin
			overheat_flag      <= 1'b0;
			stop_charging_flag <= 1'b0;
		end else if (cal_valid) begin
			overheat_flag      <= temp_code > $signed({2'b00, over_temp_threshold});
			stop_charging_flag <= charging
				&& (temp_code > $signed({2'b00, over_temp_threshold}));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			low_capacity_flag <= 1'b0;
			low_runtime_flag  <= 1'b0;
		end else if (gauge_valid) begin
			low_capacity_flag <= next_low_cap;
			low_runtime_flag  <= runtime_estimate <= low_runtime_threshold;
		end
	end

	// one broadcast per entry into low capacity, not one per measurement
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_broadcast <= 1'b0;
		end else begin
			alarm_broadcast <= gauge_valid && next_low_cap && !low_capacity_flag
				&& broadcast_enable;
		end
	end
endmodule : bac_alarm
`default_nettype wire

// ==== hdl/bac_settings.sv ====
// Purpose: battery alarm and calibration settings store with its scaling and alarms
// Assumes: the SMBus front end turns commands into byte index strobes
// Notes:   reset reloads the typical reset values and drops writes; a real part backs it with EEPROM
`timescale 1ns/100ps
`default_nettype none
module bac_settings
	import bac_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic [IDX_W-1:0]   set_index,
	input  wire logic [7:0]         set_wdata,
	input  wire logic               set_write,
	input  wire logic               set_read,
	output logic      [7:0]         set_rdata,
	output logic                    set_rvalid,
	input  wire logic [7:0]         rx_address_byte,
	output logic                    address_match,
	output bac_bus_cfg_t            bus_cfg,
	output logic      [3:0]         calibrated,
	input  wire logic               raw_valid,
	input  wire bac_raw_t           raw,
	output bac_cal_t                cal,
	output logic                    cal_valid,
	input  wire logic               charging,
	input  wire logic               gauge_valid,
	input  wire logic [15:0]        remaining_capacity,
	input  wire logic [15:0]        runtime_estimate,
	input  wire logic               broadcast_enable,
	output logic      [15:0]        alarm_warning_word,
	output logic      [15:0]        pack_status_word,
	output logic                    alarm_broadcast
);
	localparam int unsigned AW_OVERHEAT_BIT   = 15;
	localparam int unsigned AW_STOP_CHG_BIT   = 14;
	localparam int unsigned PS_LOW_CAP_BIT    = 9;
	localparam int unsigned PS_LOW_RUN_BIT    = 8;

	logic [7:0] store [NUM_SET];

	logic [15:0] over_temp_threshold;
	logic [15:0] low_cap_threshold;
	logic [15:0] low_runtime_threshold;
	logic [15:0] cur_gain;
	logic [15:0] therm_gain;
	logic [15:0] int_temp_gain;
	logic [15:0] vpack_gain;
	logic [7:0]  bus_byte;
	logic [7:0]  addr_byte;
	logic [7:0]  cal_byte;
	logic        overheat_flag;
	logic        stop_charging_flag;
	logic        low_capacity_flag;
	logic        low_runtime_flag;
	logic        in_range;

	function automatic logic [15:0] word_at(input logic [IDX_W-1:0] idx);
		return {store[idx + 5'h01], store[idx]};
	endfunction : word_at

	assign in_range = set_index < IDX_W'(NUM_SET);

	// settings store: writes land immediately and are used from the next measurement on
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NUM_SET; i++) begin
				store[i] <= bac_reset_byte(IDX_W'(i));
			end
		end else if (set_write && in_range) begin
			if (set_index == IDX_CAL_FLAGS) begin
				store[set_index] <= set_wdata & CAL_USED_MASK;
			end else begin
				store[set_index] <= set_wdata;
			end
		end
	end

	// unmapped indices read as zero and ignore writes
	always_ff @(posedge clk) begin
		if (rst) begin
			set_rdata <= 8'h00;
		end else if (set_read) begin
			set_rdata <= in_range ? store[set_index] : UNMAPPED_READ;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			set_rvalid <= 1'b0;
		end else begin
			set_rvalid <= set_read;
		end
	end

	assign bus_byte              = store[IDX_BUS_SETTINGS];
	assign addr_byte             = store[IDX_SLAVE_ADDR];
	assign cal_byte              = store[IDX_CAL_FLAGS];
	assign over_temp_threshold   = word_at(IDX_OVER_TEMP);
	assign low_cap_threshold     = word_at(IDX_LOW_CAP);
	assign low_runtime_threshold = word_at(IDX_LOW_RUNTIME);
	assign cur_gain              = word_at(IDX_CUR_GAIN);
	assign therm_gain            = word_at(IDX_THERM_GAIN);
	assign int_temp_gain         = word_at(IDX_INT_TEMP_GAIN);
	assign vpack_gain            = word_at(IDX_VPACK_GAIN);

	always_ff @(posedge clk) begin
		if (rst) begin
			bus_cfg <= '0;
		end else begin
			bus_cfg.arb_v2        <= bus_byte[BUS_ARB_V2_BIT];
			bus_cfg.master_wr_crc <= bus_byte[BUS_MWR_CRC_BIT];
			bus_cfg.pec_enable    <= bus_byte[BUS_PEC_BIT];
			bus_cfg.baud_ctrl     <= bus_byte[BUS_BAUD_CTRL_BIT];
			bus_cfg.baud_sel      <= bus_byte[BUS_BAUD_MSB:0];
		end
	end

	// the setting holds the 8-bit write form of the address; the r/w bit is not compared
	always_ff @(posedge clk) begin
		if (rst) begin
			address_match <= 1'b0;
		end else begin
			address_match <= rx_address_byte[7:1] == addr_byte[7:1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			calibrated <= 4'h0;
		end else begin
			calibrated <= {cal_byte[CAL_RC_OSCILLATOR_CALIBRATED_BIT], cal_byte[CAL_TEMP_BIT],
				cal_byte[CAL_CURRENT_BIT], cal_byte[CAL_VPACK_BIT]};
		end
	end

	// the stored internal temperature offset is kept but not applied
	bac_scale u_scale (
		.clk           (clk),
		.rst           (rst),
		.raw_valid     (raw_valid),
		.raw           (raw),
		.cur_gain      (cur_gain),
		.cur_offset    (store[IDX_CUR_OFFSET]),
		.cur_az_dev    (store[IDX_CUR_AZ_DEV]),
		.therm_gain    (therm_gain),
		.therm_offset  (store[IDX_THERM_OFFSET]),
		.int_temp_gain (int_temp_gain),
		.vpack_gain    (vpack_gain),
		.vpack_offset  (store[IDX_VPACK_OFFSET]),
		.cal           (cal),
		.cal_valid     (cal_valid)
	);

	bac_alarm u_alarm (
		.clk                   (clk),
		.rst                   (rst),
		.cal_valid             (cal_valid),
		.temperature           (cal.temperature),
		.charging              (charging),
		.gauge_valid           (gauge_valid),
		.remaining_capacity    (remaining_capacity),
		.runtime_estimate      (runtime_estimate),
		.over_temp_threshold   (over_temp_threshold),
		.low_cap_threshold     (low_cap_threshold),
		.low_runtime_threshold (low_runtime_threshold),
		.broadcast_enable      (broadcast_enable),
		.overheat_flag         (overheat_flag),
		.stop_charging_flag    (stop_charging_flag),
		.low_capacity_flag     (low_capacity_flag),
		.low_runtime_flag      (low_runtime_flag),
		.alarm_broadcast       (alarm_broadcast)
	);

	always_comb begin
		alarm_warning_word                  = 16'h0000;
		alarm_warning_word[AW_OVERHEAT_BIT] = overheat_flag;
		alarm_warning_word[AW_STOP_CHG_BIT] = stop_charging_flag;
		pack_status_word                    = 16'h0000;
		pack_status_word[PS_LOW_CAP_BIT]    = low_capacity_flag;
		pack_status_word[PS_LOW_RUN_BIT]    = low_runtime_flag;
	end
endmodule : bac_settings
`default_nettype wire

// ==== dv/bac_settings_assertions.sv ====
// Purpose: port-level checks for the settings store, scaling and alarms
// Assumes: single clock, synchronous active-high reset
// Notes:   relations span the store-to-output latency of two edges
`timescale 1ns/100ps
`default_nettype none
module bac_settings_chk
	import bac_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [IDX_W-1:0] set_index,
	input  wire logic [7:0]       set_wdata,
	input  wire logic             set_write,
	input  wire logic             set_read,
	input  wire logic [7:0]       set_rdata,
	input  wire logic             set_rvalid,
	input  wire logic [7:0]       rx_address_byte,
	input  wire logic             address_match,
	input  wire bac_bus_cfg_t     bus_cfg,
	input  wire logic [3:0]       calibrated,
	input  wire logic             raw_valid,
	input  wire logic             cal_valid,
	input  wire logic             charging,
	input  wire logic             gauge_valid,
	input  wire logic             broadcast_enable,
	input  wire logic [15:0]      alarm_warning_word,
	input  wire logic [15:0]      pack_status_word,
	input  wire logic             alarm_broadcast
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_bus_decode: assert property (
		set_write && set_index == IDX_BUS_SETTINGS |-> ##2
		bus_cfg == {$past(set_wdata[7:4], 2), $past(set_wdata[2:0], 2)})
		else $error("bus settings decode wrong");
	chk_cal_bits: assert property (
		set_write && set_index == IDX_CAL_FLAGS |-> ##2 calibrated == $past(set_wdata[7:4], 2))
		else $error("calibration bits wrong");
	chk_cal_unused: assert property (
		set_read && set_index == IDX_CAL_FLAGS |=> set_rdata[3:0] == 4'h0)
		else $error("unused calibration bits not zero");
	chk_addr_compare: assert property (
		set_write && set_index == IDX_SLAVE_ADDR |-> ##2
		address_match == ($past(rx_address_byte[7:1]) == $past(set_wdata[7:1], 2)))
		else $error("address compare wrong");
	chk_read_valid: assert property (set_rvalid == $past(set_read))
		else $error("read valid timing wrong");
	chk_read_back: assert property (
		(set_write && set_index != IDX_CAL_FLAGS && set_index < 5'h17) ##1
		(set_read && !set_write && set_index == $past(set_index)) |=> set_rdata == $past(set_wdata, 2))
		else $error("read back differs from write");
	chk_unmapped_read: assert property (
		set_read && set_index >= 5'h17 |=> set_rdata == UNMAPPED_READ)
		else $error("unmapped read not zero");
	chk_stop_charge: assert property (
		cal_valid |=> alarm_warning_word[14] == (alarm_warning_word[15] && $past(charging)))
		else $error("stop charging flag wrong");
	chk_scale_valid: assert property (raw_valid |=> cal_valid)
		else $error("scaled result late");
	chk_bcast_cause: assert property (
		alarm_broadcast |-> pack_status_word[9] && !$past(pack_status_word[9])
		&& $past(broadcast_enable) && $past(gauge_valid))
		else $error("broadcast without cause");
	chk_status_hold: assert property (!gauge_valid |=> $stable(pack_status_word))
		else $error("status changed without gauge update");
endmodule : bac_settings_chk
bind bac_settings bac_settings_chk i_bac_settings_chk (.clk(clk), .rst(rst),
	.set_index(set_index), .set_wdata(set_wdata), .set_write(set_write),
	.set_read(set_read), .set_rdata(set_rdata), .set_rvalid(set_rvalid),
	.rx_address_byte(rx_address_byte), .address_match(address_match),
	.bus_cfg(bus_cfg), .calibrated(calibrated), .raw_valid(raw_valid),
	.cal_valid(cal_valid), .charging(charging), .gauge_valid(gauge_valid),
	.broadcast_enable(broadcast_enable), .alarm_warning_word(alarm_warning_word),
	.pack_status_word(pack_status_word), .alarm_broadcast(alarm_broadcast));
`default_nettype wire

// ==== dv/bac_host.sv ====
// Purpose: host model issuing settings byte writes and reads
// Assumes: requests launched 2 ns after a rising edge, taken on the next edge
// Notes:   one idle edge between tasks keeps every strobe a single-step change
`timescale 1ns/100ps
`default_nettype none
module bac_host
	import bac_pkg::*;
(
	input  wire logic             clk,
	output var  logic [IDX_W-1:0] set_index,
	output var  logic [7:0]       set_wdata,
	output var  logic             set_write,
	output var  logic             set_read,
	input  wire logic [7:0]       set_rdata,
	input  wire logic             set_rvalid
);
	initial begin
		set_index = 5'h00;
		set_wdata = 8'h00;
		set_write = 1'b0;
		set_read = 1'b0;
	end
	task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
		@(posedge clk);
		#2;
		set_index = i;
		set_wdata = d;
		set_write = 1'b1;
		@(posedge clk);
		#2;
		set_write = 1'b0;
	endtask : wr
	// low byte first; the two bytes are not updated atomically
	task automatic wr16(input logic [IDX_W-1:0] i, input logic [15:0] v);
		wr(i, v[7:0]);
		wr(i + 5'h01, v[15:8]);
	endtask : wr16
	task automatic rd(input logic [IDX_W-1:0] i, output logic [7:0] q, output logic ok);
		@(posedge clk);
		#2;
		set_index = i;
		set_read = 1'b1;
		@(posedge clk);
		#2;
		set_read = 1'b0;
		q = set_rdata;
		ok = set_rvalid;
	endtask : rd
	task automatic wr_rd(input logic [IDX_W-1:0] i, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#2;
		set_index = i;
		set_wdata = d;
		set_write = 1'b1;
		@(posedge clk);
		#2;
		set_write = 1'b0;
		set_read = 1'b1;
		@(posedge clk);
		#2;
		set_read = 1'b0;
		q = set_rdata;
	endtask : wr_rd
	function automatic logic [15:0] cap_threshold(input int rated);
		return 16'(rated / 10);
	endfunction : cap_threshold
	function automatic logic [15:0] gain_recal(input int old_g, input int ref_c, input int rep_c);
		return 16'(old_g * ref_c / rep_c);
	endfunction : gain_recal
endmodule : bac_host
`default_nettype wire

// ==== dv/bac_settings_bench.sv ====
// Purpose: directed regression of the settings store through its byte port
// Assumes: inputs change 2 ns after the rising edge
// Notes:   expectations come from the coded formulas, not from the design
`timescale 1ns/100ps
`default_nettype none
module bac_settings_bench
	import bac_pkg::*;
;
	logic             clk, rst, set_write, set_read, set_rvalid, address_match;
	logic             raw_valid, cal_valid, charging, gauge_valid, broadcast_enable;
	logic             alarm_broadcast, ok;
	logic [IDX_W-1:0] set_index;
	logic [7:0]       set_wdata, set_rdata, rx_address_byte, q;
	logic [15:0]      remaining_capacity, runtime_estimate, alarm_warning_word;
	logic [15:0]      pack_status_word, g;
	logic [3:0]       calibrated;
	bac_bus_cfg_t     bus_cfg;
	bac_raw_t         raw;
	bac_cal_t         cal;
	int               bad_count, checks_done;
	logic [7:0]       exp_rst [23] = '{8'h21, 8'hEE, 8'h02, 8'hB8, 8'h01, 8'h0A, 8'h00, 8'h16,
		8'hF0, 8'hBC, 8'h1A, 8'h14, 8'h05, 8'hF8, 8'h5C, 8'h4D, 8'h4E, 8'hF4, 8'hF4, 8'hFE,
		8'h91, 8'hD3, 8'h00};
	bac_settings i_bac_settings (.clk(clk), .rst(rst), .set_index(set_index),
		.set_wdata(set_wdata), .set_write(set_write), .set_read(set_read),
		.set_rdata(set_rdata), .set_rvalid(set_rvalid), .rx_address_byte(rx_address_byte),
		.address_match(address_match), .bus_cfg(bus_cfg), .calibrated(calibrated),
		.raw_valid(raw_valid), .raw(raw), .cal(cal), .cal_valid(cal_valid),
		.charging(charging), .gauge_valid(gauge_valid), .remaining_capacity(remaining_capacity),
		.runtime_estimate(runtime_estimate), .broadcast_enable(broadcast_enable),
		.alarm_warning_word(alarm_warning_word), .pack_status_word(pack_status_word),
		.alarm_broadcast(alarm_broadcast));
	bac_host i_bac_host (.clk(clk), .set_index(set_index), .set_wdata(set_wdata),
		.set_write(set_write), .set_read(set_read), .set_rdata(set_rdata),
		.set_rvalid(set_rvalid));
	always #12.5 clk = ~clk;
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
		checks_done++;
		if (v !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask : chk
	task automatic meas(input logic [15:0] c, input logic [15:0] v, input logic [15:0] t,
		input logic x);
		@(posedge clk);
		#2;
		raw = '{c, v, t, x};
		raw_valid = 1'b1;
		@(posedge clk);
		#2;
		raw_valid = 1'b0;
		@(posedge clk);
		#2;
	endtask : meas
	task automatic heat(input logic [15:0] t, input logic ch, input logic [1:0] e);
		charging = ch;
		meas(16'h0000, 16'h0000, t, 1'b0);
		chk("alarm_warning_word", {e, 14'h0000}, alarm_warning_word);
	endtask : heat
	task automatic gauge(input logic [15:0] r, input logic [15:0] t, input logic [15:0] es,
		input logic eb);
		@(posedge clk);
		#2;
		remaining_capacity = r;
		runtime_estimate = t;
		gauge_valid = 1'b1;
		@(posedge clk);
		#2;
		gauge_valid = 1'b0;
		chk("pack_status_word", es, pack_status_word);
		chk("alarm_broadcast", 16'(eb), 16'(alarm_broadcast));
	endtask : gauge
	task automatic addr(input logic [7:0] a, input logic e);
		rx_address_byte = a;
		repeat (2) @(posedge clk);
		#2;
		chk("address_match", 16'(e), 16'(address_match));
	endtask : addr
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		#(25 * 5000);
		bad_count++;
		results();
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{raw_valid, charging, gauge_valid, broadcast_enable} = 4'h0;
		raw = '0;
		rx_address_byte = 8'h16;
		remaining_capacity = 16'hFFFF;
		runtime_estimate = 16'hFFFF;
		repeat (8) @(posedge clk);
		#2;
		rst = 1'b0;
		@(posedge clk);
		#2;
		chk("bus_cfg", 16'h0011, 16'(bus_cfg));
		chk("calibrated", 16'h000F, 16'(calibrated));
		for (int i = 0; i < 24; i++) begin
			i_bac_host.rd(5'(i), q, ok);
			chk("reset byte", (i < 23) ? 16'(exp_rst[i]) : 16'h0000, 16'(q));
			chk("set_rvalid", 16'h0001, 16'(ok));
		end
		foreach (exp_rst[k]) if (k < 2) begin
			g = (k == 0) ? 16'h00D6 : 16'h0029;
			i_bac_host.wr_rd(IDX_BUS_SETTINGS, g[7:0], q);
			chk("bus readback", g, 16'(q));
			chk("bus_cfg", 16'({g[7:4], g[2:0]}), 16'(bus_cfg));
		end
		i_bac_host.wr(IDX_CAL_FLAGS, 8'h5A);
		i_bac_host.rd(IDX_CAL_FLAGS, q, ok);
		chk("calibration flags", 16'h0050, 16'(q));
		chk("calibrated", 16'h0005, 16'(calibrated));
		addr(8'h17, 1'b1);
		addr(8'h18, 1'b0);
		i_bac_host.wr(IDX_SLAVE_ADDR, 8'h2C);
		addr(8'h2C, 1'b1);
		addr(8'h16, 1'b0);
		i_bac_host.wr(5'h17, 8'h5A);
		i_bac_host.wr(5'h1F, 8'hFF);
		i_bac_host.rd(5'h17, q, ok);
		chk("unmapped read", 16'h0000, 16'(q));
		i_bac_host.rd(IDX_BUS_SETTINGS, q, ok);
		chk("no alias", 16'h0029, 16'(q));
		meas(16'h3FE8, 16'h4000, 16'h4000, 1'b0);
		chk("current", 16'h1ABC, cal.current_ma);
		chk("pack voltage", 16'h4E4D, cal.pack_voltage);
		chk("internal temp", 16'h5CF8, cal.temperature);
		meas(16'h0000, 16'h0000, 16'h3FFE, 1'b1);
		chk("current", 16'h000A, cal.current_ma);
		chk("thermistor temp", 16'h0514, cal.temperature);
		i_bac_host.wr16(IDX_CUR_GAIN, 16'hFFFF);
		meas(16'h3FE8, 16'h0000, 16'h0000, 1'b0);
		chk("current max gain", 16'hFFFF, cal.current_ma);
		i_bac_host.wr16(IDX_CUR_GAIN, 16'h4000);
		i_bac_host.wr(IDX_CUR_OFFSET, 8'h7F);
		i_bac_host.wr(IDX_CUR_AZ_DEV, 8'h80);
		i_bac_host.wr(IDX_VPACK_OFFSET, 8'h80);
		meas(16'hFF9C, 16'h3F80, 16'h0000, 1'b0);
		chk("current offsets", 16'hFF9D, cal.current_ma);
		chk("pack voltage offset", 16'h4E4D, cal.pack_voltage);
		i_bac_host.wr16(IDX_INT_TEMP_GAIN, 16'h4000);
		heat(16'h0226, 1'b1, 2'b00);
		heat(16'h0227, 1'b1, 2'b11);
		heat(16'h0258, 1'b0, 2'b10);
		i_bac_host.wr16(IDX_OVER_TEMP, 16'(30 * 10 + 200));
		heat(16'h012D, 1'b1, 2'b11);
		heat(16'h012C, 1'b1, 2'b00);
		g = i_bac_host.gain_recal(16384, 270, 300);
		i_bac_host.wr16(IDX_INT_TEMP_GAIN, g);
		meas(16'h0000, 16'h0000, 16'h012C, 1'b0);
		chk("recalibrated temp", 16'((32'h12C * g) >> 14), cal.temperature);
		broadcast_enable = 1'b1;
		gauge(16'h01B9, 16'h000B, 16'h0000, 1'b0);
		gauge(16'h01B8, 16'h000A, 16'h0300, 1'b1);
		gauge(16'h01B8, 16'h000A, 16'h0300, 1'b0);
		broadcast_enable = 1'b0;
		gauge(16'h0258, 16'h000A, 16'h0100, 1'b0);
		gauge(16'h012C, 16'h0005, 16'h0300, 1'b0);
		i_bac_host.wr16(IDX_LOW_CAP, i_bac_host.cap_threshold(5000));
		broadcast_enable = 1'b1;
		gauge(16'h0258, 16'h0014, 16'h0000, 1'b0);
		gauge(16'h01F4, 16'h0014, 16'h0200, 1'b1);
		@(posedge clk);
		#2;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		rst = 1'b0;
		@(posedge clk);
		#2;
		chk("bus_cfg after reset", 16'h0011, 16'(bus_cfg));
		chk("status after reset", 16'h0000, pack_status_word);
		i_bac_host.rd(IDX_LOW_CAP, q, ok);
		chk("threshold after reset", 16'h00B8, 16'(q));
		results();
	end
endmodule : bac_settings_bench
`default_nettype wire
